// >>> verilog/frame_shape_status.v
// banked frame-shape control and first general event status register
// assumes a decoded register port on clock; bus clock arrives as an asynchronous pin
//
// How it works
// - frame-shape writes take effect only at the end of the frame in progress
// - column code 000 means 2 columns (reset), 001 means 4, 111 means 16
// - sync search completion loads detected row and column codes, overwriting
// - writing the inactive bank copy switches banks at frame end, even unchanged
// - status bit 7 is read-only, high while any unmasked second-status condition exists
// - summary bit reads 0 with nothing unmasked, its reset value, else 1
// - status bit 0 latches the combined interrupt; write 1 clears, 0 ignored
// - combined flag resets to 0 and reads 1 once the interrupt was asserted
`timescale 1ns/100ps
`include "frame_shape_consts.vh"
module frame_shape_status #(
    parameter FRAME_CNT_W = `FRAME_CNT_W
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // bus clock pin, sampled here to count bits of the frame
    input wire bus_clk_pin,
    // decoded register access
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // frame synchronisation search result
    input wire sync_done,
    input wire [4:0] detected_rows,
    input wire [2:0] detected_cols,
    // event sources
    input wire second_status_pending,
    input wire combined_irq,
    // frame geometry in use
    output reg active_bank,
    output reg [4:0] row_code,
    output reg [2:0] col_code,
    output reg frame_end
);
    wire bus_clk_rise;

    reg [7:0] bank0_reg;
    reg [7:0] bank0_next;
    reg [7:0] bank1_reg;
    reg [7:0] bank1_next;
    reg active_bank_next;
    reg pending_reg;
    reg pending_next;
    reg target_bank_reg;
    reg target_bank_next;
    reg [4:0] row_code_next;
    reg [2:0] col_code_next;
    reg [FRAME_CNT_W-1:0] bit_cnt_reg;
    reg [FRAME_CNT_W-1:0] bit_cnt_next;
    reg frame_end_next;
    reg combined_flag_reg;
    reg combined_flag_next;
    reg [7:0] rdata_next;
    reg [13:0] frame_len;
    reg [FRAME_CNT_W-1:0] frame_last;
    reg [7:0] target_value;

    edge_sync bus_clk_sync (
        .clock(clock),
        .rst(rst),
        .pin(bus_clk_pin),
        .level(),
        .rise(bus_clk_rise)
    );

    // rows per frame from the row code; the reserved codes fall back to 48 rows
    function [8:0] rows_of;
        input [4:0] code;
        begin
            case (code)
                5'h00: rows_of = 9'd48;
                5'h01: rows_of = 9'd50;
                5'h02: rows_of = 9'd60;
                5'h03: rows_of = 9'd64;
                5'h04: rows_of = 9'd75;
                5'h05: rows_of = 9'd80;
                5'h06: rows_of = 9'd125;
                5'h07: rows_of = 9'd147;
                5'h08: rows_of = 9'd96;
                5'h09: rows_of = 9'd100;
                5'h0a: rows_of = 9'd120;
                5'h0b: rows_of = 9'd128;
                5'h0c: rows_of = 9'd150;
                5'h0d: rows_of = 9'd160;
                5'h0e: rows_of = 9'd250;
                5'h10: rows_of = 9'd192;
                5'h11: rows_of = 9'd200;
                5'h12: rows_of = 9'd240;
                5'h13: rows_of = 9'd256;
                5'h14: rows_of = 9'd72;
                5'h15: rows_of = 9'd144;
                5'h16: rows_of = 9'd90;
                5'h17: rows_of = 9'd180;
                default: rows_of = 9'd48;
            endcase
        end
    endfunction

    // columns per frame: two per step of the code
    function [4:0] cols_of;
        input [2:0] code;
        begin
            cols_of = {1'b0, code, 1'b0} + 5'd2;
        end
    endfunction

    always @* begin
        // largest frame is 256 x 16 bits, which fits the counter width
        frame_len = rows_of(row_code) * cols_of(col_code);
        frame_last = frame_len[FRAME_CNT_W-1:0] - 1'b1;
    end

    // bit counter on sampled bus clock edges marks the last bit of each frame
    always @* begin
        bit_cnt_next = bit_cnt_reg;
        frame_end_next = 1'b0;
        if (sync_done) begin
            bit_cnt_next = {FRAME_CNT_W{1'b0}};
        end else if (bus_clk_rise) begin
            if (bit_cnt_reg >= frame_last) begin
                bit_cnt_next = {FRAME_CNT_W{1'b0}};
                frame_end_next = 1'b1;
            end else begin
                bit_cnt_next = bit_cnt_reg + 1'b1;
            end
        end
    end

    wire wr_bank0 = reg_wr && (reg_addr == `OFS_FRAME_SHAPE_BANK0);
    wire wr_bank1 = reg_wr && (reg_addr == `OFS_FRAME_SHAPE_BANK1);
    wire wr_status = reg_wr && (reg_addr == `OFS_EVENT_STATUS_ONE);

    // bank copies, pending switch and geometry in use
    always @* begin
        bank0_next = bank0_reg;
        bank1_next = bank1_reg;
        pending_next = pending_reg;
        target_bank_next = target_bank_reg;
        active_bank_next = active_bank;
        row_code_next = row_code;
        col_code_next = col_code;
        target_value = target_bank_reg ? bank1_reg : bank0_reg;
        if (frame_end_next && pending_reg) begin
            active_bank_next = target_bank_reg;
            row_code_next = target_value[`ROW_MSB:`ROW_LSB];
            col_code_next = target_value[`COL_MSB:`COL_LSB];
            pending_next = 1'b0;
        end
        if (wr_bank0) begin
            bank0_next = reg_wdata;
            pending_next = 1'b1;
            target_bank_next = 1'b0;
        end
        if (wr_bank1) begin
            bank1_next = reg_wdata;
            pending_next = 1'b1;
            target_bank_next = 1'b1;
        end
        // detected size overrides both the geometry and the active copy
        if (sync_done) begin
            row_code_next = detected_rows;
            col_code_next = detected_cols;
            pending_next = 1'b0;
            if (active_bank) begin
                bank1_next = {detected_rows, detected_cols};
            end else begin
                bank0_next = {detected_rows, detected_cols};
            end
        end
    end

    // sticky combined flag: a new assertion beats a same-cycle clear
    always @* begin
        combined_flag_next = combined_flag_reg;
        if (wr_status && reg_wdata[`STAT_COMBINED_BIT]) begin
            combined_flag_next = 1'b0;
        end
        if (combined_irq) begin
            combined_flag_next = 1'b1;
        end
    end

    // frame-shape copies are write-only and read as zero
    always @* begin
        rdata_next = 8'h00;
        if (reg_addr == `OFS_EVENT_STATUS_ONE) begin
            rdata_next[`STAT_SUMMARY_BIT] = second_status_pending;
            rdata_next[`STAT_COMBINED_BIT] = combined_flag_reg;
            // bits 6..1 left at zero
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            bank0_reg <= `FRAME_SHAPE_RESET;
            bank1_reg <= `FRAME_SHAPE_RESET;
            pending_reg <= 1'b0;
            target_bank_reg <= 1'b0;
            active_bank <= 1'b0;
            row_code <= `ROW_CODE_RESET;
            col_code <= `COL_CODE_RESET;
            bit_cnt_reg <= {FRAME_CNT_W{1'b0}};
            frame_end <= 1'b0;
            combined_flag_reg <= 1'b0;
            reg_rdata <= `STATUS_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            bank0_reg <= bank0_next;
            bank1_reg <= bank1_next;
            pending_reg <= pending_next;
            target_bank_reg <= target_bank_next;
            active_bank <= active_bank_next;
            row_code <= row_code_next;
            col_code <= col_code_next;
            bit_cnt_reg <= bit_cnt_next;
            frame_end <= frame_end_next;
            combined_flag_reg <= combined_flag_next;
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end
endmodule // frame_shape_status

// >>> verilog/frame_shape_consts.vh
// offsets, field positions and reset values for the frame-shape and status slice
// assumes inclusion by bare name from the design files
`ifndef FRAME_SHAPE_CONSTS_VH
`define FRAME_SHAPE_CONSTS_VH

`define ADDR_W 8
`define OFS_FRAME_SHAPE_BANK0 8'h60
`define OFS_FRAME_SHAPE_BANK1 8'h70
`define OFS_EVENT_STATUS_ONE 8'hc0

`define ROW_MSB 7
`define ROW_LSB 3
`define COL_MSB 2
`define COL_LSB 0
`define STAT_SUMMARY_BIT 7
`define STAT_COMBINED_BIT 0

`define FRAME_SHAPE_RESET 8'h00
`define COL_CODE_RESET 3'h0
`define ROW_CODE_RESET 5'h00
`define STATUS_RESET 8'h00
`define FRAME_CNT_W 13

`endif

// >>> verilog/edge_sync.v
// two-stage synchroniser for one pin with a rising-edge pulse behind it
// assumes the pin is asynchronous to clock; edge detect reads stages two and three only
`timescale 1ns/100ps
module edge_sync (
    // clock and reset
    input wire clock,
    input wire rst,
    // pin in, synchronised level and edge out
    input wire pin,
    output wire level,
    output wire rise
);
    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;

    always @(posedge clock) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            stage1_reg <= pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign level = stage2_reg;
    assign rise = stage2_reg & ~stage3_reg;
endmodule // edge_sync

// >>> verif/bus_clk_model.sv
// bus manager side: a bus clock that toggles only while a frame is sent
// assumes run comes from the bench; the clock rests low between frames
`timescale 1ns/100ps
module bus_clk_model (
    // frame control
    input wire run,
    // bus clock out
    output reg bus_clk_pin
);
    initial bus_clk_pin = 1'b0;
    // 64 ns period, phase free against the system clock
    always begin
        #32;
        bus_clk_pin = run ? ~bus_clk_pin : 1'b0;
    end
endmodule // bus_clk_model

// >>> verif/frame_shape_status_sva.sv
// checker for the frame-shape control and first event status register
// assumes a bind onto frame_shape_status with every port connected by name
`timescale 1ns/100ps
`include "frame_shape_consts.vh"
module frame_shape_status_sva #(
    parameter FRAME_CNT_W = `FRAME_CNT_W
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // register access
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    // sync result and event sources
    input wire sync_done,
    input wire [4:0] detected_rows,
    input wire [2:0] detected_cols,
    input wire second_status_pending,
    input wire combined_irq,
    // geometry
    input wire active_bank,
    input wire [4:0] row_code,
    input wire [2:0] col_code,
    input wire frame_end
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence clr_s;
        reg_wr && reg_addr == `OFS_EVENT_STATUS_ONE && reg_wdata[0] && !combined_irq;
    endsequence
    sequence quiet_rd_s;
        !combined_irq ##1 (!combined_irq && reg_rd && reg_addr == `OFS_EVENT_STATUS_ONE);
    endsequence
    rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
    no_answer_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
    summary_live_a: assert property (reg_rd && reg_addr == `OFS_EVENT_STATUS_ONE
        |=> reg_rdata[7] == $past(second_status_pending)) else $error("summary bit wrong");
    reserved_zero_a: assert property (reg_rvalid |-> reg_rdata[6:1] == 6'h00)
        else $error("reserved bits set");
    flag_set_a: assert property (combined_irq [*2] ##1 (reg_rd && reg_addr ==
        `OFS_EVENT_STATUS_ONE) |=> reg_rdata[0]) else $error("combined flag not set");
    flag_clear_a: assert property (clr_s ##1 quiet_rd_s |=> !reg_rdata[0])
        else $error("combined flag not cleared");
    shape_hold_a: assert property (!frame_end && !$past(sync_done) && !$past(rst)
        |-> $stable({active_bank, row_code, col_code})) else $error("geometry moved early");
    sync_load_a: assert property (sync_done |=> row_code == $past(detected_rows)
        && col_code == $past(detected_cols)) else $error("detected size not loaded");
    end_pulse_a: assert property (frame_end |=> !frame_end) else $error("frame end too long");
endmodule // frame_shape_status_sva

// >>> verif/tb_top.sv
// self-checking bench for the frame-shape control and status slice
// assumes the checker and the bus clock model are compiled before this file
`timescale 1ns/100ps
`include "frame_shape_consts.vh"
module tb_top;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg sync_done = 1'b0;
    reg [4:0] detected_rows = 5'h00;
    reg [2:0] detected_cols = 3'h0;
    reg second_status_pending = 1'b0;
    reg combined_irq = 1'b0;
    reg run = 1'b0;
    wire bus_clk_pin;
    wire [7:0] reg_rdata;
    wire reg_rvalid;
    wire active_bank;
    wire frame_end;
    wire [4:0] row_code;
    wire [2:0] col_code;
    integer mismatches = 0;
    integer cmp_count = 0;
    integer i;
    integer rise_cnt = 0;
    always #2.5 clock = ~clock;
    // counts bus clock bits so the frame length can be checked against the row and column codes
    always @(posedge bus_clk_pin) rise_cnt = rise_cnt + 1;
    bus_clk_model u_mgr (.run(run), .bus_clk_pin(bus_clk_pin));
    frame_shape_status #(.FRAME_CNT_W(13)) u_dut (.clock(clock), .rst(rst),
        .bus_clk_pin(bus_clk_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sync_done(sync_done), .detected_rows(detected_rows), .detected_cols(detected_cols),
        .second_status_pending(second_status_pending), .combined_irq(combined_irq),
        .active_bank(active_bank), .row_code(row_code), .col_code(col_code),
        .frame_end(frame_end));
    task test_done;
    begin
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task step;
    begin
        @(posedge clock);
        #1;
    end
    endtask
    // every access leaves one idle cycle so no strobe is set twice at one edge
    task wr(input [7:0] a, input [7:0] d);
    begin
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step;
        reg_wr = 1'b0;
        step;
    end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
    begin
        reg_addr = a;
        reg_rd = 1'b1;
        step;
        reg_rd = 1'b0;
        check(reg_rdata, exp);
        check({7'h00, reg_rvalid}, 8'h01);
        step;
    end
    endtask
    task wait_fe;
    begin
        i = 0;
        while (frame_end !== 1'b1 && i < 12000) begin
            step;
            i = i + 1;
        end
        if (i == 12000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        step;
        rd(`OFS_EVENT_STATUS_ONE, 8'h00);
        second_status_pending = 1'b1;
        wr(`OFS_EVENT_STATUS_ONE, 8'hfe);
        rd(`OFS_EVENT_STATUS_ONE, 8'h80);
        second_status_pending = 1'b0;
        combined_irq = 1'b1;
        step;
        step;
        combined_irq = 1'b0;
        rd(`OFS_EVENT_STATUS_ONE, 8'h01);
        wr(`OFS_EVENT_STATUS_ONE, 8'h00);
        rd(`OFS_EVENT_STATUS_ONE, 8'h01);
        wr(`OFS_EVENT_STATUS_ONE, 8'h01);
        rd(`OFS_EVENT_STATUS_ONE, 8'h00);
        detected_rows = 5'h01;
        sync_done = 1'b1;
        step;
        sync_done = 1'b0;
        check({row_code, col_code}, 8'h08);
        wr(`OFS_FRAME_SHAPE_BANK1, 8'h07);
        check({row_code, col_code}, 8'h08);
        run = 1'b1;
        wait_fe;
        check({7'h00, active_bank}, 8'h01);
        check({row_code, col_code}, 8'h07);
        wr(`OFS_FRAME_SHAPE_BANK0, 8'h07);
        wait_fe;
        check({7'h00, active_bank}, 8'h00);
        wr(`OFS_FRAME_SHAPE_BANK1, 8'h01);
        wait_fe;
        check({row_code, col_code}, 8'h01);
        rise_cnt = 0;
        // bank 0 rewritten with the value it already holds
        wr(`OFS_FRAME_SHAPE_BANK0, 8'h07);
        wait_fe;
        check(rise_cnt[7:0], 8'hc0);
        check({7'h00, active_bank}, 8'h00);
        check({row_code, col_code}, 8'h07);
        run = 1'b0;
        test_done;
    end
endmodule // tb_top
bind frame_shape_status frame_shape_status_sva #(.FRAME_CNT_W(FRAME_CNT_W)) u_sva (
    .clock(clock),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .sync_done(sync_done),
    .detected_rows(detected_rows),
    .detected_cols(detected_cols),
    .second_status_pending(second_status_pending),
    .combined_irq(combined_irq),
    .active_bank(active_bank),
    .row_code(row_code),
    .col_code(col_code),
    .frame_end(frame_end)
);
